// >>> ssc_pkg.sv
package ssc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // Register offsets on the host register port.
  localparam logic [7:0] ADDR_RATIO      = 8'h0A;
  localparam logic [7:0] ADDR_SAMPLE_DIV = 8'h12;
  localparam logic [7:0] ADDR_SYNC_CFG   = 8'h4F;
  localparam logic [7:0] ADDR_PIN_CAL    = 8'h50;
  localparam logic [7:0] ADDR_HOLD       = 8'h5F;

  // Values after reset.
  localparam logic [15:0] RST_SAMPLE_DIV = 16'h0028;
  localparam logic [15:0] RST_SYNC_CFG   = 16'h2000;
  localparam logic [15:0] RST_PIN_CAL    = 16'h0000;
  localparam logic [15:0] RST_HOLD       = 16'h0000;

  // Field positions.
  localparam int unsigned SYNC_SEL_LSB   = 2;
  localparam int unsigned PIN_A_IE_BIT   = 1;
  localparam int unsigned PIN_B_IE_BIT   = 5;
  localparam int unsigned PIN_B_OE_BIT   = 6;
  localparam int unsigned PIN_B_SRC_BIT  = 6;
  localparam int unsigned CAL_START_BIT  = 5;
  localparam int unsigned HOLD_B_BIT     = 2;
  localparam int unsigned HOLD_A_BIT     = 1;
  localparam int unsigned CAL_CLK_EN_BIT = 0;
  localparam int unsigned RATIO_BUSY_BIT = 15;

  // Sample trigger source codes.
  localparam logic [1:0] SEL_INTERNAL = 2'h0;
  localparam logic [1:0] SEL_PIN_A    = 2'h1;
  localparam logic [1:0] SEL_PIN_B    = 2'h2;

  // Log2 of the slow clock cycles per divider unit.
  localparam int unsigned PERIOD_MULT_SHIFT = 2;

  // Index of each asynchronous input inside the synchroniser vector.
  localparam int unsigned SYN_SLOW  = 0;
  localparam int unsigned SYN_FAST  = 1;
  localparam int unsigned SYN_PIN_A = 2;
  localparam int unsigned SYN_PIN_B = 3;
  localparam int unsigned SYN_N     = 4;

  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_ALIGN,
    CAL_COUNT
  } ssc_cal_state_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } ssc_reg_req_s;

  typedef struct packed {
    logic out;
    logic oe;
  } ssc_pin_drive_s;

endpackage

// >>> ssc_sample_sync_cal_hold_ctrl.sv
`timescale 1ns/100ps
module ssc_sample_sync_cal_hold_ctrl #(
  parameter int unsigned RATIO_W    = 12,
  parameter int unsigned CAL_WINDOW = 1
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire ssc_pkg::ssc_reg_req_s  reg_req,
  output logic [15:0]                 reg_rdata,
  input  wire logic                   slow_clk_in,
  input  wire logic                   fast_osc_toggle,
  input  wire logic                   aux_pin_a_in,
  input  wire logic                   aux_pin_b_in,
  output ssc_pkg::ssc_pin_drive_s     aux_pin_b_drv,
  input  wire logic                   analog_front_end_pwrdn,
  output logic                        sample_start,
  output logic                        cal_fast_clock_en,
  input  wire logic [15:0]            slot_a_data,
  input  wire logic                   slot_a_valid,
  input  wire logic [15:0]            slot_b_data,
  input  wire logic                   slot_b_valid,
  output logic [15:0]                 slot_a_result,
  output logic [15:0]                 slot_b_result
);

  generate
    if (RATIO_W < 4 || RATIO_W > 15) begin : g_bad_ratio_w
      $error("RATIO_W must lie between 4 and 15");
    end
    if (CAL_WINDOW < 1 || CAL_WINDOW > 255) begin : g_bad_window
      $error("CAL_WINDOW must lie between 1 and 255");
    end
  endgenerate

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction

  // Saturating count step, shared by the running count and the closing latch.
  function automatic logic [RATIO_W-1:0] sat_inc(input logic [RATIO_W-1:0] cnt, input logic hit);
    sat_inc = (hit && !(&cnt)) ? cnt + RATIO_W'(1) : cnt;
  endfunction

  logic [15:0]               sample_div_q;
  logic [15:0]               sync_cfg_q;
  logic [15:0]               pin_cal_q;
  logic [15:0]               hold_q;
  logic [ssc_pkg::SYN_N-1:0] sync1_q;
  logic [ssc_pkg::SYN_N-1:0] sync2_q;
  logic [ssc_pkg::SYN_N-1:0] prev_q;
  logic [17:0]               period_cnt_q;
  logic [17:0]               period_target;
  logic                      slow_edge;
  logic                      fast_edge;
  logic                      pin_a_edge;
  logic                      pin_b_edge;
  logic [1:0]                trig_sel;
  logic                      sample_d;
  logic                      cal_start_prev_q;
  logic                      cal_go;
  ssc_pkg::ssc_cal_state_e   cal_state_q;
  logic [7:0]                cal_win_q;
  logic [RATIO_W-1:0]        ratio_cnt_q;
  logic [RATIO_W-1:0]        ratio_q;
  logic                      cal_busy;
  logic [15:0]               rdata_d;

  // Software registers. Reserved bits are stored as written so a read returns them.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_div_q <= ssc_pkg::RST_SAMPLE_DIV;
      sync_cfg_q   <= ssc_pkg::RST_SYNC_CFG;
      pin_cal_q    <= ssc_pkg::RST_PIN_CAL;
      hold_q       <= ssc_pkg::RST_HOLD;
    end else if (reg_req.wr) begin
      unique case (reg_req.addr)
        ssc_pkg::ADDR_SAMPLE_DIV: sample_div_q <= reg_req.wdata;
        ssc_pkg::ADDR_SYNC_CFG:   sync_cfg_q   <= reg_req.wdata;
        ssc_pkg::ADDR_PIN_CAL:    pin_cal_q    <= reg_req.wdata;
        ssc_pkg::ADDR_HOLD:       hold_q       <= reg_req.wdata;
        default: begin
        end
      endcase
    end
  end

  // Read data; unmapped offsets read as zero.
  always_comb begin
    rdata_d = 16'h0000;
    unique case (reg_req.addr)
      ssc_pkg::ADDR_SAMPLE_DIV: rdata_d = sample_div_q;
      ssc_pkg::ADDR_SYNC_CFG:   rdata_d = sync_cfg_q;
      ssc_pkg::ADDR_PIN_CAL:    rdata_d = pin_cal_q;
      ssc_pkg::ADDR_HOLD:       rdata_d = hold_q;
      ssc_pkg::ADDR_RATIO: begin
        rdata_d[RATIO_W-1:0]             = ratio_q;
        rdata_d[ssc_pkg::RATIO_BUSY_BIT] = cal_busy;
      end
      default: rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_req.rd) begin
      reg_rdata <= rdata_d;
    end
  end

  // Two-stage synchronisers for the slow clock, the oscillator tap and both pins.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end else begin
      sync1_q <= {aux_pin_b_in, aux_pin_a_in, fast_osc_toggle, slow_clk_in};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign slow_edge  = rise(sync2_q[ssc_pkg::SYN_SLOW], prev_q[ssc_pkg::SYN_SLOW]);
  // The oscillator tap is a divided toggle, so both of its edges count.
  assign fast_edge  = sync2_q[ssc_pkg::SYN_FAST] ^ prev_q[ssc_pkg::SYN_FAST];
  assign pin_a_edge = rise(sync2_q[ssc_pkg::SYN_PIN_A], prev_q[ssc_pkg::SYN_PIN_A])
                      & sync_cfg_q[ssc_pkg::PIN_A_IE_BIT];
  assign pin_b_edge = rise(sync2_q[ssc_pkg::SYN_PIN_B], prev_q[ssc_pkg::SYN_PIN_B])
                      & sync_cfg_q[ssc_pkg::PIN_B_IE_BIT];

  assign trig_sel      = sync_cfg_q[ssc_pkg::SYNC_SEL_LSB +: 2];
  assign period_target = {sample_div_q, 2'b00};

  // Internal period counter. It restarts whenever another source is chosen, so a
  // switch back to internal timing always begins with a full period.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt_q <= 18'h00000;
    end else if (trig_sel != ssc_pkg::SEL_INTERNAL || sample_div_q == 16'h0000) begin
      period_cnt_q <= 18'h00000;
    end else if (slow_edge) begin
      if (period_cnt_q >= period_target - 18'h00001) begin
        period_cnt_q <= 18'h00000;
      end else begin
        period_cnt_q <= period_cnt_q + 18'h00001;
      end
    end
  end

  // Code 11 selects nothing, so a reserved setting simply stops sampling.
  always_comb begin
    sample_d = 1'b0;
    unique case (trig_sel)
      ssc_pkg::SEL_INTERNAL: sample_d = slow_edge && sample_div_q != 16'h0000
                                        && period_cnt_q >= period_target - 18'h00001;
      ssc_pkg::SEL_PIN_A:    sample_d = pin_a_edge;
      ssc_pkg::SEL_PIN_B:    sample_d = pin_b_edge;
      default:               sample_d = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_start <= 1'b0;
    end else begin
      sample_start <= sample_d;
    end
  end

  // Pin B drive. The source bit is only looked at while the enable is set.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_pin_b_drv <= '0;
    end else begin
      aux_pin_b_drv.oe <= sync_cfg_q[ssc_pkg::PIN_B_OE_BIT];
      if (sync_cfg_q[ssc_pkg::PIN_B_OE_BIT] && pin_cal_q[ssc_pkg::PIN_B_SRC_BIT]) begin
        aux_pin_b_drv.out <= analog_front_end_pwrdn;
      end else begin
        aux_pin_b_drv.out <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_fast_clock_en <= 1'b0;
    end else begin
      cal_fast_clock_en <= hold_q[ssc_pkg::CAL_CLK_EN_BIT];
    end
  end

  // Only a 0 to 1 change of the start bit begins a count, which is why software
  // has to clear it before asking again.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_start_prev_q <= 1'b0;
    end else begin
      cal_start_prev_q <= pin_cal_q[ssc_pkg::CAL_START_BIT];
    end
  end

  assign cal_go   = pin_cal_q[ssc_pkg::CAL_START_BIT] & ~cal_start_prev_q;
  assign cal_busy = cal_state_q != ssc_pkg::CAL_IDLE;

  // Ratio count: oscillator edges over CAL_WINDOW slow periods, aligned to a slow
  // edge. The count saturates instead of wrapping, so an oversized ratio reads as
  // all ones rather than a small wrong number.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_state_q <= ssc_pkg::CAL_IDLE;
      cal_win_q   <= 8'h00;
      ratio_cnt_q <= '0;
      ratio_q     <= '0;
    end else begin
      unique case (cal_state_q)
        ssc_pkg::CAL_IDLE: begin
          if (cal_go) begin
            cal_state_q <= ssc_pkg::CAL_ALIGN;
          end
        end
        ssc_pkg::CAL_ALIGN: begin
          if (slow_edge) begin
            cal_state_q <= ssc_pkg::CAL_COUNT;
            cal_win_q   <= 8'h00;
            ratio_cnt_q <= '0;
          end
        end
        ssc_pkg::CAL_COUNT: begin
          ratio_cnt_q <= sat_inc(ratio_cnt_q, fast_edge && cal_fast_clock_en);
          if (slow_edge) begin
            if (cal_win_q == 8'(CAL_WINDOW - 1)) begin
              // An oscillator edge on the closing slow edge still belongs to this window.
              ratio_q     <= sat_inc(ratio_cnt_q, fast_edge && cal_fast_clock_en);
              cal_state_q <= ssc_pkg::CAL_IDLE;
            end else begin
              cal_win_q <= cal_win_q + 8'h01;
            end
          end
        end
        default: cal_state_q <= ssc_pkg::CAL_IDLE;
      endcase
    end
  end

  // Result registers for the two time slots; a set hold bit freezes them.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_a_result <= 16'h0000;
    end else if (slot_a_valid && !hold_q[ssc_pkg::HOLD_A_BIT]) begin
      slot_a_result <= slot_a_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_b_result <= 16'h0000;
    end else if (slot_b_valid && !hold_q[ssc_pkg::HOLD_B_BIT]) begin
      slot_b_result <= slot_b_data;
    end
  end

endmodule // ssc_sample_sync_cal_hold_ctrl

// >>> ssc_checker.sv
`timescale 1ns/100ps
module ssc_checker (
  input wire logic                    ref_clk,
  input wire logic                    rst_n,
  input wire ssc_pkg::ssc_reg_req_s   reg_req,
  input wire ssc_pkg::ssc_pin_drive_s aux_pin_b_drv,
  input wire logic                    analog_front_end_pwrdn,
  input wire logic                    sample_start,
  input wire logic                    cal_fast_clock_en,
  input wire logic [15:0]             slot_a_data,
  input wire logic                    slot_a_valid,
  input wire logic [15:0]             slot_b_data,
  input wire logic                    slot_b_valid,
  input wire logic [15:0]             slot_a_result,
  input wire logic [15:0]             slot_b_result
);
  logic [15:0] cfg_q;
  logic [15:0] pin_q;
  logic [15:0] hold_q;
  // Shadow copies let the checker judge outputs without seeing the register bodies.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= ssc_pkg::RST_SYNC_CFG;
      pin_q <= ssc_pkg::RST_PIN_CAL;
      hold_q <= ssc_pkg::RST_HOLD;
    end else if (reg_req.wr) begin
      if (reg_req.addr == ssc_pkg::ADDR_SYNC_CFG) cfg_q <= reg_req.wdata;
      if (reg_req.addr == ssc_pkg::ADDR_PIN_CAL) pin_q <= reg_req.wdata;
      if (reg_req.addr == ssc_pkg::ADDR_HOLD) hold_q <= reg_req.wdata;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr_cfg;
    reg_req.wr && reg_req.addr == ssc_pkg::ADDR_SYNC_CFG;
  endsequence
  sequence s_wr_hold;
    reg_req.wr && reg_req.addr == ssc_pkg::ADDR_HOLD;
  endsequence
  property p_oe;
    s_wr_cfg |-> ##2 aux_pin_b_drv.oe == $past(reg_req.wdata[6], 2);
  endproperty
  property p_off;
    !aux_pin_b_drv.oe |-> !aux_pin_b_drv.out;
  endproperty
  property p_src;
    1'b1 |=> aux_pin_b_drv.out == $past(cfg_q[6] & pin_q[6] & analog_front_end_pwrdn);
  endproperty
  property p_cal;
    s_wr_hold |-> ##2 cal_fast_clock_en == $past(reg_req.wdata[0], 2);
  endproperty
  property p_hold_a;
    slot_a_valid |=> slot_a_result ==
      ($past(hold_q[1]) ? $past(slot_a_result) : $past(slot_a_data));
  endproperty
  property p_hold_b;
    slot_b_valid |=> slot_b_result ==
      ($past(hold_q[2]) ? $past(slot_b_result) : $past(slot_b_data));
  endproperty
  property p_pulse;
    sample_start |=> !sample_start;
  endproperty
  property p_ie_a;
    cfg_q[3:2] == 2'h1 && !cfg_q[1] |=> !sample_start;
  endproperty
  a_oe: assert property (p_oe) else $error("pin B enable wrong");
  a_off: assert property (p_off) else $error("pin B out while off");
  a_src: assert property (p_src) else $error("pin B source wrong");
  a_cal: assert property (p_cal) else $error("cal clock enable wrong");
  a_hold_a: assert property (p_hold_a) else $error("slot A result wrong");
  a_hold_b: assert property (p_hold_b) else $error("slot B result wrong");
  a_pulse: assert property (p_pulse) else $error("sample pulse too long");
  a_ie_a: assert property (p_ie_a) else $error("pulse with pin A off");
endmodule // ssc_checker
bind ssc_sample_sync_cal_hold_ctrl ssc_checker u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req), .aux_pin_b_drv(aux_pin_b_drv),
  .analog_front_end_pwrdn(analog_front_end_pwrdn), .sample_start(sample_start),
  .cal_fast_clock_en(cal_fast_clock_en), .slot_a_data(slot_a_data),
  .slot_a_valid(slot_a_valid), .slot_b_data(slot_b_data), .slot_b_valid(slot_b_valid),
  .slot_a_result(slot_a_result), .slot_b_result(slot_b_result)
);

// >>> ssc_host_model.sv
`timescale 1ns/100ps
module ssc_host_model (
  input  wire logic             ref_clk,
  output ssc_pkg::ssc_reg_req_s reg_req,
  input  wire logic [15:0]      reg_rdata
);
  initial reg_req = '0;
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = d;
    if (a == ssc_pkg::ADDR_PIN_CAL) v = d & 16'h0060;
    if (a == ssc_pkg::ADDR_HOLD) v = d & 16'h0007;
    if (a == ssc_pkg::ADDR_SYNC_CFG && v[3:2] == 2'h3) v[3:2] = 2'h0;
    @(posedge ref_clk);
    #1 reg_req = '{1'b1, 1'b0, a, v};
    @(posedge ref_clk);
    #1 reg_req = '{1'b0, 1'b0, ~a, ~v};
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    #1 reg_req = '{1'b0, 1'b1, a, reg_req.wdata};
    @(posedge ref_clk);
    #1 reg_req = '{1'b0, 1'b0, ~a, ~reg_req.wdata};
    d = reg_rdata;
  endtask
  // A new count needs the start bit seen low first, so it is always cleared before set.
  task automatic start_ratio();
    wr(ssc_pkg::ADDR_PIN_CAL, 16'h0000);
    wr(ssc_pkg::ADDR_PIN_CAL, 16'h0020);
  endtask
endmodule // ssc_host_model

// >>> sample_sync_cal_hold_ctrl_bench.sv
`timescale 1ns/100ps
module sample_sync_cal_hold_ctrl_bench;
  localparam int SH = 20;
  localparam int FH = 4;
  localparam int CW = 2;
  logic                   ref_clk, rst_n, slow, fast, pin_a, pin_b, pwrdn, va, vb;
  logic                   sample_start, cal_en;
  logic [15:0]            reg_rdata, da, db, ra, rb, rv, cfg, ea, eb;
  ssc_pkg::ssc_reg_req_s  reg_req;
  ssc_pkg::ssc_pin_drive_s drv;
  int                     n_mismatch, tests_run, n_pulse, gap, cyc, last_c, seed, k, np;
  logic [7:0]             ta [5] = '{8'h12, 8'h4F, 8'h50, 8'h5F, 8'h33};
  logic [15:0]            tx [5] = '{16'h0028, 16'h2000, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0]            pc [4] = '{16'h0006, 16'h0004, 16'h0028, 16'h0008};
  ssc_host_model u_host (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
  ssc_sample_sync_cal_hold_ctrl #(.CAL_WINDOW(CW)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .slow_clk_in(slow), .fast_osc_toggle(fast), .aux_pin_a_in(pin_a), .aux_pin_b_in(pin_b),
    .aux_pin_b_drv(drv), .analog_front_end_pwrdn(pwrdn), .sample_start(sample_start),
    .cal_fast_clock_en(cal_en), .slot_a_data(da), .slot_a_valid(va), .slot_b_data(db),
    .slot_b_valid(vb), .slot_a_result(ra), .slot_b_result(rb));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    {slow, fast} = 2'h0;
    forever begin
      repeat (FH) @(posedge ref_clk);
      #1 fast = ~fast;
      if (cyc % SH < FH) slow = ~slow;
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (sample_start === 1'b1) begin
      n_pulse++;
      gap = cyc - last_c;
      last_c = cyc;
    end
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Registered outputs follow a register write by one more clock edge.
  task automatic settle;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic pin_trig(input logic b, input logic [15:0] c, input int exp);
    u_host.wr(ssc_pkg::ADDR_SYNC_CFG, c);
    np = n_pulse;
    if (b) pin_b = 1'b1;
    else pin_a = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1 {pin_a, pin_b} = 2'h0;
    repeat (8) @(posedge ref_clk);
    chk("pulse count", 16'(exp), 16'(n_pulse - np));
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    n_mismatch++;
    end_of_test;
  end
  initial begin
    seed = $urandom(32'h8755);
    {rst_n, pin_a, pin_b, pwrdn, va, vb, da, db} = '0;
    repeat (3) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 5; i++) begin
      u_host.rd(ta[i], rv);
      chk("reset value", tx[i], rv);
    end
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      cfg = 16'($urandom) & 16'hFFF3;
      rv = 16'($urandom) | (i < 2 ? 16'h0040 : 16'h0000);
      if (i < 2) cfg[6] = 1'b1;
      pwrdn = rv[0] | (i == 0);
      u_host.wr(ssc_pkg::ADDR_SYNC_CFG, cfg);
      u_host.wr(ssc_pkg::ADDR_PIN_CAL, rv);
      settle;
      chk("pin B enable", 16'(cfg[6]), 16'(drv.oe));
      chk("pin B out", 16'(cfg[6] & rv[6] & pwrdn), 16'(drv.out));
      u_host.rd(ssc_pkg::ADDR_SYNC_CFG, rv);
      chk("config readback", cfg, rv);
    end
    $display("test pin B drive done");
    k = 1 + $urandom % 3;
    u_host.wr(ssc_pkg::ADDR_SAMPLE_DIV, 16'(k));
    u_host.wr(ssc_pkg::ADDR_SYNC_CFG, 16'h0000);
    np = n_pulse;
    for (int i = 0; i < 3000 && n_pulse < np + 3; i++) @(posedge ref_clk);
    chk("sample gap", 16'(4 * k * 2 * SH), 16'(gap));
    $display("test internal timing done");
    for (int i = 0; i < 4; i++) pin_trig(i[1], pc[i], 1 - i % 2);
    $display("test pin triggers done");
    for (int i = 0; i < 4; i++) begin
      u_host.wr(ssc_pkg::ADDR_HOLD, {13'h0, 2'(i), 1'b0});
      {ea, eb} = {ra, rb};
      @(posedge ref_clk);
      #1 {da, db, va, vb} = {16'($urandom), 16'($urandom), 2'h3};
      if (i % 2 == 0) ea = da;
      if (i < 2) eb = db;
      @(posedge ref_clk);
      #1 {da, db, va, vb} = {~da, ~db, 2'h0};
      chk("slot A result", ea, ra);
      chk("slot B result", eb, rb);
    end
    $display("test result holds done");
    u_host.wr(ssc_pkg::ADDR_HOLD, 16'h0001);
    settle;
    chk("cal clock enable", 16'h0001, 16'(cal_en));
    u_host.start_ratio();
    repeat (3) @(posedge ref_clk);
    k = 0;
    do begin
      u_host.rd(ssc_pkg::ADDR_RATIO, rv);
      k++;
    end while (rv[15] !== 1'b0 && k < 200);
    chk("ratio", 16'(CW * 2 * SH / FH), rv & 16'h0FFF);
    u_host.wr(ssc_pkg::ADDR_HOLD, 16'h0000);
    settle;
    chk("cal clock enable", 16'h0000, 16'(cal_en));
    $display("test ratio done");
    end_of_test;
  end
endmodule // sample_sync_cal_hold_ctrl_bench
